//--- verilog/dma_pkg.sv
// Constants, enumerations and bus carriers of the four-channel DMA controller.
// Assumes an APB register bus and a byte-wide data bus, all on one clock.
package dma_pkg;
    localparam int NUM_CH = 4;
    localparam int AW     = 16;

    // Global register byte offsets
    localparam logic [11:0] A_GCTRL = 12'h000;
    localparam logic [11:0] A_STAT  = 12'h004;
    localparam logic [11:0] A_MASK  = 12'h008;
    localparam logic [11:0] A_BUSY  = 12'h00C;
    // Channel space: paddr[11:7] selects it, paddr[6:5] the channel
    localparam logic [4:0]  CH_AREA = 5'h02;
    localparam logic [4:0]  O_CCTRL = 5'h00;
    localparam logic [4:0]  O_SRC   = 5'h04;
    localparam logic [4:0]  O_DST   = 5'h08;
    localparam logic [4:0]  O_BLK   = 5'h0C;
    localparam logic [4:0]  O_REP   = 5'h10;

    // Global control fields
    localparam int G_EN     = 0;
    localparam int G_RR     = 1;
    localparam int G_LINK01 = 2;
    localparam int G_LINK23 = 3;
    // Channel control fields
    localparam int C_EN    = 0;
    localparam int C_BLEN  = 1;
    localparam int C_REPEN = 3;
    localparam int C_TRIG  = 4;
    localparam int C_SWREQ = 6;
    localparam int C_SMODE = 7;
    localparam int C_DMODE = 9;
    localparam int C_SRLD  = 11;
    localparam int C_DRLD  = 13;
    localparam int C_CRC   = 15;

    // Reset values
    localparam logic [3:0]    GCTRL_RST = 4'h0;
    localparam logic [7:0]    STAT_RST  = 8'h00;
    localparam logic [7:0]    MASK_RST  = 8'h00;
    localparam logic [15:0]   CCTRL_RST = 16'h0000;
    localparam logic [AW-1:0] ADDR_RST  = 16'h0000;
    localparam logic [15:0]   BLK_RST   = 16'h0001;
    localparam logic [7:0]    REP_RST   = 8'h00;

    // Data space regions
    localparam logic [AW-1:0] EE_BASE   = 16'h1000;
    localparam logic [AW-1:0] EE_END    = 16'h1800;
    localparam logic [AW-1:0] SRAM_BASE = 16'h2000;
    localparam logic [AW-1:0] SRAM_LAST = 16'h3FFF;

    // Read latencies in cycles, first byte and burst follow-on
    localparam logic [1:0] LAT_IO         = 2'h1;
    localparam logic [1:0] LAT_SRAM_ONE   = 2'h2;
    localparam logic [1:0] LAT_SRAM_BURST = 2'h1;
    localparam logic [1:0] LAT_EE_ONE     = 2'h3;
    localparam logic [1:0] LAT_EE_BURST   = 2'h2;

    typedef enum logic [1:0] {
        AM_FIXED = 2'h0,
        AM_INC   = 2'h1,
        AM_DEC   = 2'h2
    } addr_mode_t;

    typedef enum logic [1:0] {
        RL_NONE  = 2'h0,
        RL_BURST = 2'h1,
        RL_BLOCK = 2'h2,
        RL_TRANS = 2'h3
    } reload_t;

    typedef enum logic [1:0] {
        TR_SW     = 2'h0,
        TR_PERIPH = 2'h1,
        TR_EVENT  = 2'h2
    } trig_t;

    typedef struct packed {
        logic          req;
        logic [AW-1:0] addr;
    } mem_rd_t;

    typedef struct packed {
        logic          req;
        logic [AW-1:0] addr;
        logic [7:0]    data;
    } mem_wr_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } crc_feed_t;
endpackage

//--- verilog/dma_addr_gen.sv
// Next-address logic for one side (source or destination) of a channel.
// Assumes the end flags nest: transaction end implies block and burst end.
`timescale 1ns/1ps
`default_nettype none
module dma_addr_gen
    import dma_pkg::*;
(
    input  wire logic [AW-1:0] cur,
    input  wire logic [AW-1:0] start,
    input  wire logic [1:0]    mode,
    input  wire logic [1:0]    reload,
    input  wire logic          end_burst,
    input  wire logic          end_block,
    input  wire logic          end_trans,
    output logic      [AW-1:0] next
);
    wire logic [AW-1:0] stepped;
    wire logic          do_reload;

    assign stepped = (mode == AM_INC) ? cur + 16'h0001 :
                     (mode == AM_DEC) ? cur - 16'h0001 : cur;
    assign do_reload = (reload == RL_BURST && end_burst) ||
                       (reload == RL_BLOCK && end_block) ||
                       (reload == RL_TRANS && end_trans);
    assign next = do_reload ? start : stepped;
endmodule
`default_nettype wire

//--- verilog/dma_arb.sv
// Channel arbiter: fixed order (lowest index first) or round robin.
// Assumes it is consulted only while the engine is free.
`timescale 1ns/1ps
`default_nettype none
module dma_arb
    import dma_pkg::*;
#(
    parameter int N  = NUM_CH,
    parameter int IW = $clog2(N)
)
(
    input  wire logic [N-1:0]  req,
    input  wire logic          rr,
    input  wire logic [IW-1:0] last,
    output logic               any,
    output logic      [IW-1:0] gnt
);
    always_comb begin
        logic [IW-1:0] idx;
        idx = '0;
        any = 1'b0;
        gnt = '0;
        for (int k = 0; k < N; k++) begin
            idx = rr ? IW'(int'(last) + 1 + k) : IW'(k);
            if (!any && req[idx]) begin
                any = 1'b1;
                gnt = idx;
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/dma_ctrl.sv
// Four-channel DMA controller top: APB registers, channels, transfer engine.
// Assumes rd_data answers a read at the documented latency on the same clock,
// and that trigger inputs come from logic on this clock.
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl
    import dma_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NUM_CH-1:0] periph_req,
    input  wire logic [NUM_CH-1:0] event_in,
    output mem_rd_t                rd_o,
    input  wire logic [7:0]        rd_data,
    output mem_wr_t                wr_o,
    output crc_feed_t              crc_o,
    output logic      [NUM_CH-1:0] ch_irq,
    output logic                   irq
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RD   = 2'b10
    } state_t;

    function automatic logic bad_addr(input logic [AW-1:0] a);
        return (a >= EE_END && a < SRAM_BASE) || a > SRAM_LAST;
    endfunction

    function automatic logic [1:0] rd_lat(input logic [AW-1:0] a, input logic burst);
        if (a < EE_BASE)
            return LAT_IO;
        else if (a < SRAM_BASE)
            return burst ? LAT_EE_BURST : LAT_EE_ONE;
        return burst ? LAT_SRAM_BURST : LAT_SRAM_ONE;
    endfunction

    // Global registers
    logic [3:0]  gctrl_r;
    logic [7:0]  stat_r;
    logic [7:0]  stat_nxt;
    logic [7:0]  mask_r;
    logic [31:0] prdata_r;

    // Per-channel registers and running state
    logic [15:0]    cctrl_r    [NUM_CH];
    logic [15:0]    cctrl_nxt  [NUM_CH];
    logic [AW-1:0]  src_r      [NUM_CH];
    logic [AW-1:0]  dst_r      [NUM_CH];
    logic [15:0]    blk_r      [NUM_CH];
    logic [7:0]     rep_r      [NUM_CH];
    logic [AW-1:0]  cur_src_r  [NUM_CH];
    logic [AW-1:0]  cur_dst_r  [NUM_CH];
    logic [16:0]    blk_left_r [NUM_CH];
    logic [7:0]     rep_left_r [NUM_CH];
    logic           busy_r     [NUM_CH];
    logic [31:0]    ch_rd      [NUM_CH];
    logic [NUM_CH-1:0] busy_v;
    logic [NUM_CH-1:0] start;
    logic [NUM_CH-1:0] link_go;
    logic [NUM_CH-1:0] err_hit;
    logic [NUM_CH-1:0] done_set;
    logic [NUM_CH-1:0] chan_req;

    // Engine state
    state_t      state_r;
    logic [1:0]  act_r;
    logic [3:0]  beat_r;
    logic [1:0]  wait_r;
    mem_rd_t     rd_r;
    mem_wr_t     wr_r;
    crc_feed_t   crc_r;

    // Register bus decode
    wire logic       wr_acc   = psel & penable & pwrite & ce;
    wire logic       rd_setup = psel & ~penable & ~pwrite & ce;
    wire logic       rd_done  = psel & penable & ~pwrite & ce;
    wire logic       in_ch    = paddr[11:7] == CH_AREA;
    wire logic [1:0] sel_ch   = paddr[6:5];
    wire logic [4:0] off      = paddr[4:0];
    wire logic       hit_g    = paddr inside {A_GCTRL, A_STAT, A_MASK, A_BUSY};
    wire logic       hit_c    = in_ch & (off inside {O_CCTRL, O_SRC, O_DST, O_BLK, O_REP});
    wire logic       hit      = hit_g | hit_c;
    wire logic       stat_rc  = rd_done & (paddr == A_STAT);

    wire logic [31:0] rd_mux = in_ch              ? ch_rd[sel_ch] :
                               (paddr == A_GCTRL) ? {28'h0000000, gctrl_r} :
                               (paddr == A_STAT)  ? {24'h000000, stat_r} :
                               (paddr == A_MASK)  ? {24'h000000, mask_r} :
                               (paddr == A_BUSY)  ? {28'h0000000, busy_v} : 32'h00000000;

    assign pready  = ce;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_r;

    // Active and candidate channel views
    wire logic        arb_any;
    wire logic [1:0]  gnt;
    wire logic [15:0] g_ctl = cctrl_r[gnt];
    wire logic [AW-1:0] g_src = cur_src_r[gnt];
    wire logic [AW-1:0] g_dst = cur_dst_r[gnt];
    wire logic [15:0] a_ctl = cctrl_r[act_r];
    wire logic [AW-1:0] a_src = cur_src_r[act_r];
    wire logic [AW-1:0] a_dst = cur_dst_r[act_r];
    wire logic [16:0] a_blk = blk_left_r[act_r];
    wire logic [7:0]  a_rep = rep_left_r[act_r];
    wire logic [7:0]  rep_dec = a_rep - 8'h01;

    wire logic g_bad_src = bad_addr(g_src);
    wire logic g_bad_dst = bad_addr(g_dst);
    wire logic g_bad     = g_bad_src | g_bad_dst;
    wire logic grant = (state_r == ST_IDLE) & arb_any;
    wire logic [3:0] g_blen = 4'h1 << g_ctl[C_BLEN +: 2];
    wire logic [1:0] g_lat  = rd_lat(g_src, 1'b0);

    wire logic step      = (state_r == ST_RD) & (wait_r == 2'h1);
    wire logic blk_last  = a_blk == 17'h00001;
    wire logic end_trans = blk_last & (~a_ctl[C_REPEN] | rep_dec == 8'h00);
    wire logic end_burst = (beat_r == 4'h1) | blk_last;
    wire logic [AW-1:0] nsrc;
    wire logic [AW-1:0] ndst;
    wire logic [1:0]    n_lat = rd_lat(nsrc, 1'b1);

    dma_arb #(
        .N  (NUM_CH),
        .IW (2)
    ) u_arb (
        .req  (chan_req),
        .rr   (gctrl_r[G_RR]),
        .last (act_r),
        .any  (arb_any),
        .gnt  (gnt)
    );

    dma_addr_gen u_src_gen (
        .cur       (a_src),
        .start     (src_r[act_r]),
        .mode      (a_ctl[C_SMODE +: 2]),
        .reload    (a_ctl[C_SRLD +: 2]),
        .end_burst (end_burst),
        .end_block (blk_last),
        .end_trans (end_trans),
        .next      (nsrc)
    );

    dma_addr_gen u_dst_gen (
        .cur       (a_dst),
        .start     (dst_r[act_r]),
        .mode      (a_ctl[C_DMODE +: 2]),
        .reload    (a_ctl[C_DRLD +: 2]),
        .end_burst (end_burst),
        .end_block (blk_last),
        .end_trans (end_trans),
        .next      (ndst)
    );

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            wire logic       sel_me = in_ch & (sel_ch == 2'(i));
            wire logic       cw     = wr_acc & sel_me & (off == O_CCTRL);
            wire logic       link_en = (i < 2) ? gctrl_r[G_LINK01] : gctrl_r[G_LINK23];
            wire logic [1:0] tsel   = cctrl_r[i][C_TRIG +: 2];
            wire logic       fire   = (tsel == TR_SW)     ? cctrl_r[i][C_SWREQ] :
                                      (tsel == TR_PERIPH) ? periph_req[i] :
                                      (tsel == TR_EVENT)  ? event_in[i] : 1'b0;

            assign link_go[i]  = done_set[i ^ 1] & link_en & ~busy_r[i];
            assign start[i]    = gctrl_r[G_EN] & ~busy_r[i] &
                                 ((cctrl_r[i][C_EN] & fire) | link_go[i]);
            assign err_hit[i]  = grant & g_bad & (gnt == 2'(i));
            assign done_set[i] = step & end_trans & (act_r == 2'(i));
            assign busy_v[i]   = busy_r[i];
            assign chan_req[i] = busy_r[i] & gctrl_r[G_EN];
            assign ch_rd[i]    = (off == O_CCTRL) ? {16'h0000, cctrl_r[i]} :
                                 (off == O_SRC)   ? {16'h0000, src_r[i]} :
                                 (off == O_DST)   ? {16'h0000, dst_r[i]} :
                                 (off == O_BLK)   ? {16'h0000, blk_r[i]} :
                                 (off == O_REP)   ? {24'h000000, rep_r[i]} : 32'h00000000;

            always_comb begin
                cctrl_nxt[i] = cw ? pwdata[15:0] : cctrl_r[i];
                cctrl_nxt[i][C_SWREQ] = cw ? pwdata[C_SWREQ] : cctrl_r[i][C_SWREQ] & ~start[i];
                if (err_hit[i])
                    cctrl_nxt[i][C_EN] = 1'b0;
                if (link_go[i])
                    cctrl_nxt[i][C_EN] = 1'b1;
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cctrl_r[i] <= CCTRL_RST;
                    src_r[i]   <= ADDR_RST;
                    dst_r[i]   <= ADDR_RST;
                    blk_r[i]   <= BLK_RST;
                    rep_r[i]   <= REP_RST;
                end else if (ce) begin
                    cctrl_r[i] <= cctrl_nxt[i];
                    if (wr_acc && sel_me && off == O_SRC)
                        src_r[i] <= pwdata[AW-1:0];
                    if (wr_acc && sel_me && off == O_DST)
                        dst_r[i] <= pwdata[AW-1:0];
                    if (wr_acc && sel_me && off == O_BLK)
                        blk_r[i] <= pwdata[15:0];
                    if (wr_acc && sel_me && off == O_REP)
                        rep_r[i] <= pwdata[7:0];
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cur_src_r[i]  <= ADDR_RST;
                    cur_dst_r[i]  <= ADDR_RST;
                    blk_left_r[i] <= 17'h00000;
                    rep_left_r[i] <= 8'h00;
                    busy_r[i]     <= 1'b0;
                end else if (ce) begin
                    if (start[i]) begin
                        cur_src_r[i]  <= src_r[i];
                        cur_dst_r[i]  <= dst_r[i];
                        blk_left_r[i] <= {blk_r[i] == 16'h0000, blk_r[i]};
                        rep_left_r[i] <= rep_r[i];
                        busy_r[i]     <= 1'b1;
                    end else if (err_hit[i]) begin
                        busy_r[i] <= 1'b0;
                    end else if (step && act_r == 2'(i)) begin
                        cur_src_r[i]  <= nsrc;
                        cur_dst_r[i]  <= ndst;
                        blk_left_r[i] <= blk_last ? {blk_r[i] == 16'h0000, blk_r[i]}
                                                  : blk_left_r[i] - 17'h00001;
                        if (blk_last && cctrl_r[i][C_REPEN])
                            rep_left_r[i] <= rep_dec;
                        if (end_trans)
                            busy_r[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    wire logic [7:0] stat_clr = stat_rc ? prdata_r[7:0] : 8'h00;
    wire logic [7:0] stat_set = {err_hit, done_set};
    assign stat_nxt = (stat_r & ~stat_clr) | stat_set;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gctrl_r  <= GCTRL_RST;
            mask_r   <= MASK_RST;
            stat_r   <= STAT_RST;
            prdata_r <= 32'h00000000;
        end else if (ce) begin
            if (wr_acc && paddr == A_GCTRL)
                gctrl_r <= pwdata[3:0];
            if (wr_acc && paddr == A_MASK)
                mask_r <= pwdata[7:0];
            if (rd_setup)
                prdata_r <= rd_mux;
            stat_r <= stat_nxt;
        end
    end

    wire logic [NUM_CH-1:0] done_irq = stat_r[3:0] & mask_r[3:0];
    wire logic [NUM_CH-1:0] err_irq  = stat_r[7:4] & mask_r[7:4];
    assign ch_irq = done_irq | err_irq;
    assign irq    = |ch_irq;

    // Transfer engine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            act_r   <= 2'h0;
            beat_r  <= 4'h0;
            wait_r  <= 2'h0;
            rd_r    <= '0;
            wr_r    <= '0;
            crc_r   <= '0;
        end else if (ce) begin
            wr_r.req    <= 1'b0;
            crc_r.valid <= 1'b0;
            rd_r.req    <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (arb_any) begin
                        act_r <= gnt;
                        if (!g_bad) begin
                            rd_r    <= '{req: 1'b1, addr: g_src};
                            wait_r  <= g_lat;
                            beat_r  <= g_blen;
                            state_r <= ST_RD;
                        end
                    end
                end
                ST_RD: begin
                    if (wait_r == 2'h1) begin
                        wr_r   <= '{req: 1'b1, addr: a_dst, data: rd_data};
                        crc_r  <= '{valid: a_ctl[C_CRC], data: rd_data};
                        beat_r <= beat_r - 4'h1;
                        if (!end_burst) begin
                            rd_r   <= '{req: 1'b1, addr: nsrc};
                            wait_r <= n_lat;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end else begin
                        wait_r <= wait_r - 2'h1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign rd_o  = rd_r;
    assign wr_o  = wr_r;
    assign crc_o = crc_r;
endmodule
`default_nettype wire

//--- tb/dma_mem_model.sv
// Read side of the data bus: answers each read at its region's latency.
// Assumes reads come from the DMA engine; writes are observed by the bench.
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model
    import dma_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    arst_n,
    input  wire mem_rd_t rd_i,
    output logic [7:0]   rd_data
);
    logic [AW-1:0] a_r, a;
    logic [1:0]    n_r, n, lat;
    logic          act_r, cap_r, fol_r, act, fol;
    function automatic logic [7:0] pat(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'hA5;
    endfunction
    assign a   = rd_i.req ? rd_i.addr : a_r;
    assign n   = rd_i.req ? 2'h1 : n_r;
    assign act = rd_i.req | act_r;
    assign fol = rd_i.req ? cap_r : fol_r;
    assign lat = (a < EE_BASE) ? LAT_IO :
                 (a < SRAM_BASE) ? (fol ? LAT_EE_BURST : LAT_EE_ONE) :
                 (fol ? LAT_SRAM_BURST : LAT_SRAM_ONE);
    assign rd_data = (act && n == lat) ? pat(a) : ~pat(a);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_r   <= '0;
            n_r   <= 2'h0;
            act_r <= 1'h0;
            cap_r <= 1'h0;
            fol_r <= 1'h0;
        end else begin
            a_r   <= a;
            n_r   <= n + 2'h1;
            act_r <= act && n != lat;
            cap_r <= act && n == lat;
            fol_r <= fol;
        end
    end
endmodule
`default_nettype wire

//--- tb/dma_ctrl_monitor.sv
// Assertions on the DMA controller's data bus and interrupt ports.
// Assumes ce stays high; bound from the bench.
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_monitor
    import dma_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire mem_rd_t           rd_o,
    input  wire logic [7:0]        rd_data,
    input  wire mem_wr_t           wr_o,
    input  wire crc_feed_t         crc_o,
    input  wire logic [NUM_CH-1:0] ch_irq,
    input  wire logic              irq
);
    logic io, ee, sr;
    assign io = rd_o.addr < EE_BASE;
    assign ee = rd_o.addr >= EE_BASE && rd_o.addr < SRAM_BASE;
    assign sr = rd_o.addr >= SRAM_BASE;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_wr_data: assert property (wr_o.req |-> wr_o.data == $past(rd_data))
        else $error("written byte differs from read byte");
    a_io_lat: assert property (rd_o.req && io |=> wr_o.req)
        else $error("register read not one cycle");
    a_ee_first: assert property (rd_o.req && !wr_o.req && ee |=> !wr_o.req[*2] ##1 wr_o.req)
        else $error("eeprom single read not three cycles");
    a_ee_burst: assert property (rd_o.req && wr_o.req && ee |=> !wr_o.req ##1 wr_o.req)
        else $error("eeprom burst read not two cycles");
    a_sram_first: assert property (rd_o.req && !wr_o.req && sr |=> !wr_o.req ##1 wr_o.req)
        else $error("sram single read not two cycles");
    a_sram_burst: assert property (rd_o.req && wr_o.req && sr |=> wr_o.req)
        else $error("sram burst read not one cycle");
    a_irq_any: assert property (irq == |ch_irq)
        else $error("irq differs from channel requests");
    a_crc_pair: assert property (crc_o.valid |-> wr_o.req && crc_o.data == wr_o.data)
        else $error("crc byte not paired with write");
    c_crc: cover property (crc_o.valid);
    c_burst: cover property (rd_o.req && wr_o.req);
    c_irq: cover property (irq);
endmodule
`default_nettype wire

//--- tb/dma_ctrl_bench.sv
// Self-checking bench of the four-channel DMA controller.
// Assumes the read model answers memory reads; ce is held high.
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_bench
    import dma_pkg::*;
;
    logic        clk, arst_n, ce, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  periph_req, event_in, ch_irq;
    logic [7:0]  rd_data;
    mem_rd_t     rd_o;
    mem_wr_t     wr_o;
    crc_feed_t   crc_o;
    logic [23:0] wq[$];
    int          bad_count, compares, crc_n;
    dma_ctrl u_dma_ctrl (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_req(periph_req), .event_in(event_in), .rd_o(rd_o),
        .rd_data(rd_data), .wr_o(wr_o), .crc_o(crc_o), .ch_irq(ch_irq), .irq(irq));
    dma_mem_model u_dma_mem_model (.clk(clk), .arst_n(arst_n), .rd_i(rd_o), .rd_data(rd_data));
    always #2.5 clk = ~clk;
    always @(posedge clk) if (wr_o.req === 1'h1) wq.push_back({wr_o.addr, wr_o.data});
    always @(posedge clk) if (crc_o.valid === 1'h1) crc_n++;
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            $display("mismatch %s exp %h got %h", s, x, g);
            bad_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input string s, input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(s, x, q);
    endtask
    function automatic logic [11:0] ca(input int c, input logic [4:0] o);
        return 12'h100 + 12'(c * 32) + 12'(o);
    endfunction
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    task automatic ew(input logic [15:0] a, input logic [15:0] s);
        logic [23:0] v;
        if (wq.size() != 0) v = wq.pop_front();
        chk("mem write", 32'({a, pat(s)}), 32'(v));
    endtask
    task automatic go(input int c, input logic [15:0] s, d, b, input logic [31:0] r, w);
        wr(ca(c, O_SRC), 32'(s));
        wr(ca(c, O_DST), 32'(d));
        wr(ca(c, O_BLK), 32'(b));
        wr(ca(c, O_REP), r);
        wr(ca(c, O_CCTRL), w);
    endtask
    task automatic idle;
        q = 32'h1;
        while (q[3:0] !== 4'h0) begin
            apb(1'h0, A_BUSY, 32'h0);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        {clk, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {ce, periph_req, event_in} = 9'h100;
        repeat (5) @(posedge clk);
        arst_n <= 1'h1;
        rd("gctrl reset", A_GCTRL, 32'h0);
        rd("block reset", ca(0, O_BLK), 32'h1);
        rd("unmapped", 12'h044, 32'h0);
        chk("unmapped err", 32'h1, 32'(e));
        wr(A_BUSY, 32'hF);
        rd("busy", A_BUSY, 32'h0);
        wr(A_MASK, 32'hFF);
        wr(A_GCTRL, 32'h1);
        go(0, 16'h2010, 16'h2100, 16'h3, 32'h0, 32'h84C3);
        idle;
        for (int i = 0; i < 3; i++) ew(16'h2100 - 16'(i), 16'h2010 + 16'(i));
        chk("irq", 32'h1, 32'(irq));
        rd("stat", A_STAT, 32'h1);
        rd("stat cleared", A_STAT, 32'h0);
        $display("test sram burst finished");
        wr(A_MASK, 32'h0);
        go(1, 16'h0040, 16'h2200, 16'h4, 32'h2, 32'h421D);
        @(posedge clk);
        periph_req <= 4'h2;
        @(posedge clk);
        periph_req <= 4'h0;
        idle;
        for (int i = 0; i < 8; i++) ew(16'h2200 + 16'(i % 4), 16'h0040);
        chk("masked irq", 32'h0, 32'(irq));
        rd("stat", A_STAT, 32'h2);
        $display("test repeat finished");
        wr(A_MASK, 32'hFF);
        go(2, 16'h1000, 16'h0080, 16'h8, 32'h0, 32'h00A7);
        @(posedge clk);
        event_in <= 4'h4;
        @(posedge clk);
        event_in <= 4'h0;
        idle;
        for (int i = 0; i < 8; i++) ew(16'h0080, 16'h1000 + 16'(i));
        rd("stat", A_STAT, 32'h4);
        $display("test eeprom finished");
        go(3, 16'h1800, 16'h2000, 16'h1, 32'h0, 32'h0041);
        idle;
        chk("error irq", 32'h1, 32'(irq));
        rd("stat", A_STAT, 32'h80);
        chk("no write", 32'h0, 32'(wq.size()));
        $display("test error finished");
        wr(A_GCTRL, 32'h5);
        go(1, 16'h1800, 16'h2000, 16'h1, 32'h0, 32'h0);
        go(0, 16'h2010, 16'h2100, 16'h1, 32'h0, 32'h0041);
        idle;
        ew(16'h2100, 16'h2010);
        chk("ch irq", 32'h3, 32'(ch_irq));
        rd("stat", A_STAT, 32'h21);
        $display("test link finished");
        go(2, 16'h2040, 16'h2300, 16'h1, 32'h0, 32'h0021);
        go(3, 16'h2050, 16'h2400, 16'h4, 32'h0, 32'h02A3);
        @(posedge clk);
        event_in <= 4'h8;
        @(posedge clk);
        event_in <= 4'h4;
        @(posedge clk);
        event_in <= 4'h0;
        idle;
        for (int i = 0; i < 2; i++) ew(16'h2400 + 16'(i), 16'h2050 + 16'(i));
        ew(16'h2300, 16'h2040);
        for (int i = 2; i < 4; i++) ew(16'h2400 + 16'(i), 16'h2050 + 16'(i));
        rd("stat", A_STAT, 32'h0C);
        chk("crc bytes", 32'h3, 32'(crc_n));
        $display("test priority finished");
        end_of_test;
    end
    initial begin
        #100000;
        bad_count++;
        end_of_test;
    end
endmodule
bind dma_ctrl dma_ctrl_monitor u_mon (.clk(clk), .arst_n(arst_n), .rd_o(rd_o),
    .rd_data(rd_data), .wr_o(wr_o), .crc_o(crc_o), .ch_irq(ch_irq), .irq(irq));
`default_nettype wire
